// ---- timer_channel_control_flags_test.sv ----
// Self-checking bench of the timer control block.
// Assumes a 40 MHz bus clock and zero wait-state APB answers.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module timer_channel_control_flags_test;
	logic                        clk;
	logic                        rst;
	timer_ctrl_pkg::apb_req_type req;
	timer_ctrl_pkg::apb_rsp_type rsp;
	logic [7:0]                  pin_in;
	logic [7:0]                  pin_out;
	logic [7:0]                  oe_n;
	logic [7:0]                  irq;
	logic [7:0]                  src;
	logic [7:0]                  v;
	logic                        ovf;
	logic [31:0]                 rd;
	logic [15:0]                 c0;
	logic [7:0]                  exp_v;
	logic [7:0]                  exp_q [$];
	logic [1:0]                  code [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h2};
	integer                      seed;
	integer                      failures;
	integer                      tests_run;
	timer_ctrl dut(.I_CLK_SYS(clk), .I_RST(rst), .I_APB(req), .O_APB(rsp),
		.I_CH_PIN(pin_in), .O_CH_PIN(pin_out), .O_CH_PIN_OE_N(oe_n),
		.O_CH_IRQ(irq), .O_OVF_IRQ(ovf));
	timer_ctrl_pins pins(.i_pin_out(pin_out), .i_pin_oe_n(oe_n),
		.i_source(src), .o_level(pin_in));
	// One APB transfer; the request stands until pready is seen high.
	task automatic bus(input logic w, input logic [7:0] ix,
		input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, {ix, 2'h0}, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		// Outputs launched at the access edge are looked at once settled.
		@(negedge clk);
	endtask
	task automatic rchk(input logic [7:0] ix, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, ix, 32'h0000_0000);
	endtask
	task automatic wait_irq(input int b);
		for (int n = 0; n < 300 && irq[b] !== 1'b1; n++)
			@(negedge clk);
	endtask
	task automatic final_report();
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Noted read results are compared when the access completes; the note
	// is taken off once, since the check names its expected value twice.
	always @(posedge clk)
		if (req.psel && req.penable && !req.pwrite && exp_q.size() > 0)
		begin
			exp_v = exp_q.pop_front();
			`CHK("read", exp_v, rsp.prdata[7:0])
		end
	// The overflow wait dominates the run, so the limit sits above it.
	initial
	begin
		repeat (90000) @(posedge clk);
		failures++;
		final_report();
	end
	initial
	begin
		seed = 21050;
		failures = 0;
		tests_run = 0;
		req = '0;
		src = 8'h00;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int i = 8; i < 16; i++)
			rchk(8'(i), 8'h00);
		rchk(8'h3F, 8'h00);
		for (int i = 8; i < 14; i++)
		begin
			v = 8'($random(seed));
			bus(1'b1, 8'(i), {24'h000000, v});
			rchk(8'(i), i == 13 ? v & timer_ctrl_pkg::SYSCTL_TWO_MASK : v);
		end
		bus(1'b1, 8'h09, 32'h0000_0003);
		bus(1'b1, 8'h25, 32'h0000_0001);
		`CHK("pin enable", 1'b1, oe_n[0])
		bus(1'b1, 8'h25, 32'h0000_0000);
		`CHK("pin enable", 1'b0, oe_n[0])
		// Channel 7 is compare with no action, as the modulus reset needs.
		bus(1'b1, 8'h00, 32'h0000_0081);
		bus(1'b1, 8'h08, 32'h0000_0000);
		bus(1'b1, 8'h10, 32'h0000_0010);
		bus(1'b1, 8'h1E, 32'h0000_0020);
		bus(1'b1, 8'h0C, 32'h0000_0083);
		bus(1'b1, 8'h0D, 32'h0000_0008);
		bus(1'b1, 8'h06, 32'h0000_0080);
		for (int k = 0; k < 5; k++)
		begin
			if (k == 4)
				bus(1'b1, 8'h24, 32'h0000_0001);
			bus(1'b1, 8'h09, {30'h0, code[k]});
			bus(1'b1, 8'h0E, 32'h0000_0001);
			wait_irq(0);
			`CHK("flag 0", 1'b1, irq[0])
			`CHK("pin 0", 5'b11101 >> k & 5'h01, {4'h0, pin_out[0]})
		end
		bus(1'b0, 8'h04, 32'h0000_0000);
		`CHK("modulus", 1'b1, rd[15:0] <= 16'h0020)
		bus(1'b1, 8'h06, 32'h0000_0000);
		bus(1'b1, 8'h0E, 32'h0000_0001);
		`CHK("flag kept", 1'b1, irq[0])
		bus(1'b1, 8'h20, 32'h0000_0040);
		bus(1'b1, 8'h06, 32'h0000_0010);
		bus(1'b1, 8'h10, 32'h0000_0010);
		`CHK("fast clear", 1'b0, irq[0])
		bus(1'b1, 8'h0E, 32'h0000_0080);
		`CHK("pa clear", 1'b0, irq[7])
		bus(1'b1, 8'h20, 32'h0000_0000);
		bus(1'b1, 8'h06, 32'h0000_0080);
		// Each edge code against one rising and one falling edge.
		for (int c = 0; c < 4; c++)
		begin
			bus(1'b1, 8'h0B, 32'(c) << 2);
			bus(1'b1, 8'h0E, 32'h0000_0002);
			@(posedge clk);
			src[1] <= 1'b1;
			repeat (6) @(negedge clk);
			`CHK("rise", c[0], irq[1])
			bus(1'b1, 8'h0E, 32'h0000_0002);
			@(posedge clk);
			src[1] <= 1'b0;
			repeat (6) @(negedge clk);
			`CHK("fall", c[1], irq[1])
		end
		// A window of 4 ticks always holds exactly 4 counts.
		for (int p = 0; p < 8; p += 3)
		begin
			bus(1'b1, 8'h0D, 32'(p));
			repeat (300) @(posedge clk);
			bus(1'b0, 8'h04, 32'h0000_0000);
			c0 = rd[15:0];
			repeat ((4 << p) - 3) @(posedge clk);
			bus(1'b0, 8'h04, 32'h0000_0000);
			`CHK("ticks", 16'h0004, 16'(rd[15:0] - c0))
		end
		bus(1'b1, 8'h0D, 32'h0000_0080);
		for (int n = 0; n < 70000 && ovf !== 1'b1; n++)
			@(negedge clk);
		`CHK("overflow", 1'b1, ovf)
		bus(1'b1, 8'h06, 32'h0000_0010);
		bus(1'b1, 8'h20, 32'h0000_0040);
		bus(1'b0, 8'h04, 32'h0000_0000);
		`CHK("fast ovf clear", 1'b0, ovf)
		// A reset in mid-run zeroes the counter and frees the one-time
		// precision choice, so the hold and the precision divider are seen.
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		bus(1'b1, 8'h26, 32'h0000_0003);
		bus(1'b1, 8'h00, 32'h0000_0080);
		bus(1'b1, 8'h0D, 32'h0000_0008);
		bus(1'b1, 8'h06, 32'h0000_0088);
		repeat (20) @(posedge clk);
		bus(1'b0, 8'h04, 32'h0000_0000);
		`CHK("held", 16'h0000, rd[15:0])
		bus(1'b1, 8'h0D, 32'h0000_0000);
		repeat (300) @(posedge clk);
		bus(1'b0, 8'h04, 32'h0000_0000);
		c0 = rd[15:0];
		repeat (13) @(posedge clk);
		bus(1'b0, 8'h04, 32'h0000_0000);
		`CHK("precision", 16'h0004, 16'(rd[15:0] - c0))
		final_report();
	end
endmodule // timer_channel_control_flags_test
bind timer_ctrl timer_ctrl_monitor mon(.I_CLK_SYS, .I_RST, .I_APB, .O_APB,
	.I_CH_PIN, .O_CH_PIN, .O_CH_PIN_OE_N, .O_CH_IRQ, .O_OVF_IRQ);
`default_nettype wire

// ---- timer_ctrl.sv ----
// Control and status logic of an eight-channel 16-bit capture/compare timer.
// Assumes one bus clock, an APB master, and external drivers resolving pins.
`timescale 1ns/100ps
`default_nettype none

module timer_ctrl
(
	// Clock and reset.
	input  wire logic                        I_CLK_SYS,
	input  wire logic                        I_RST,
	// Register bus.
	input  wire timer_ctrl_pkg::apb_req_type I_APB,
	output var  timer_ctrl_pkg::apb_rsp_type O_APB,
	// Timer pins.
	input  wire logic [7:0]                  I_CH_PIN,
	output var  logic [7:0]                  O_CH_PIN,
	output var  logic [7:0]                  O_CH_PIN_OE_N,
	// Interrupt requests.
	output var  logic [7:0]                  O_CH_IRQ,
	output var  logic                        O_OVF_IRQ
);

	timer_ctrl_pkg::tim_state_type st_reg;
	timer_ctrl_pkg::tim_state_type st_next;

	logic        timer_en;
	logic        fast_clear;
	logic        cnt_rst_7;
	logic        tick;
	logic [7:0]  div_m1_sel;
	logic [15:0] act_ctrl;
	logic [15:0] edge_ctrl;
	logic [7:0]  rise;
	logic [7:0]  fall;
	logic [7:0]  hit;
	logic [7:0]  cap;
	logic [7:0]  out_next;
	logic [7:0]  drive;
	logic        setup;
	logic        access;
	logic [7:0]  idx;
	logic        cmp_sel;
	logic [2:0]  cmp_ch;
	logic [31:0] rd_val;
	logic        mapped;
	logic [7:0]  clr_ch;
	logic        clr_ovf;
	logic        ovf_set;

	// Control fields used across the block.
	assign timer_en   = st_reg.sysctl_one[timer_ctrl_pkg::BIT_TIMER_EN];
	assign fast_clear = st_reg.sysctl_one[timer_ctrl_pkg::BIT_FAST_CLEAR];
	assign cnt_rst_7  = st_reg.sysctl_two[timer_ctrl_pkg::BIT_CNT_RST_7];
	assign act_ctrl   = {st_reg.cmp_act_hi, st_reg.cmp_act_lo};
	assign edge_ctrl  = {st_reg.edge_hi, st_reg.edge_lo};

	// Divider choice; the precision register divides by its value plus one.
	assign div_m1_sel = st_reg.sysctl_one[timer_ctrl_pkg::BIT_PREC_SEL]
		? st_reg.prec_prescale
		: 8'((timer_ctrl_pkg::PRE_ONE
			<< st_reg.sysctl_two[timer_ctrl_pkg::PRESCALE_W-1:0])
			- timer_ctrl_pkg::PRE_ONE);

	// A tick ends each prescaler period, when all stages wrap to zero.
	assign tick = timer_en && (st_reg.pre_cnt == st_reg.pre_div_m1);

	// Edges are taken only from the second synchroniser stage onward.
	assign rise = st_reg.in_sync & ~st_reg.in_prev;
	assign fall = ~st_reg.in_sync & st_reg.in_prev;

	// Per-channel capture, compare and pin logic.
	for (genvar ch = 0; ch < 8; ch++)
	begin : g_ch
		logic om;
		logic ol;
		assign om = act_ctrl[2*ch+1];
		assign ol = act_ctrl[2*ch];
		// Compare is checked once per count value, as the count leaves it.
		assign hit[ch] = tick && st_reg.capcmp_sel[ch]
			&& (st_reg.free_counter == st_reg.cmp_val[ch]);
		assign cap[ch] = timer_en && !st_reg.capcmp_sel[ch]
			&& ((edge_ctrl[2*ch] && rise[ch])
			|| (edge_ctrl[2*ch+1] && fall[ch]));
		assign out_next[ch] = (hit[ch] && !st_reg.ch7_mask[ch])
			? (om ? ol : (ol ? !st_reg.out_line[ch]
				: st_reg.out_line[ch]))
			: st_reg.out_line[ch];
		assign drive[ch] = (om || ol) && !st_reg.pin_disc[ch];
	end

	// Pins and interrupt requests.
	assign O_CH_PIN      = st_reg.out_line;
	assign O_CH_PIN_OE_N = ~drive;
	assign O_CH_IRQ      = st_reg.ch_flag & st_reg.ch_irq_en;
	assign O_OVF_IRQ     = st_reg.ovf_flag[timer_ctrl_pkg::BIT_OVF_FLAG]
		&& st_reg.sysctl_two[timer_ctrl_pkg::BIT_OVF_IRQ_EN];

	// Bus phases; the slave never waits, so every access ends in one cycle.
	assign setup   = I_APB.psel && !I_APB.penable;
	assign access  = I_APB.psel && I_APB.penable;
	assign idx     = I_APB.paddr[timer_ctrl_pkg::ADDR_W-1:2];
	assign cmp_sel = (idx[7:4] == timer_ctrl_pkg::IDX_CMP_VAL_HIGH)
		&& !idx[0];
	assign cmp_ch  = idx[3:1];

	assign O_APB.prdata  = st_reg.rdata;
	assign O_APB.pready  = 1'b1;
	assign O_APB.pslverr = access && !mapped;

	// Read decode; an unmapped address reads zero and answers an error.
	always_comb
	begin
		rd_val = timer_ctrl_pkg::RST_DATA;
		mapped = 1'b1;
		case (idx)
			timer_ctrl_pkg::IDX_CAPCMP_SEL:    rd_val[7:0] = st_reg.capcmp_sel;
			timer_ctrl_pkg::IDX_FREE_COUNTER:
				rd_val[15:0] = st_reg.free_counter;
			timer_ctrl_pkg::IDX_SYSCTL_ONE:    rd_val[7:0] = st_reg.sysctl_one;
			timer_ctrl_pkg::IDX_CMP_ACT_HI:    rd_val[7:0] = st_reg.cmp_act_hi;
			timer_ctrl_pkg::IDX_CMP_ACT_LO:    rd_val[7:0] = st_reg.cmp_act_lo;
			timer_ctrl_pkg::IDX_EDGE_HI:       rd_val[7:0] = st_reg.edge_hi;
			timer_ctrl_pkg::IDX_EDGE_LO:       rd_val[7:0] = st_reg.edge_lo;
			timer_ctrl_pkg::IDX_CH_IRQ_EN:     rd_val[7:0] = st_reg.ch_irq_en;
			timer_ctrl_pkg::IDX_SYSCTL_TWO:    rd_val[7:0] = st_reg.sysctl_two;
			timer_ctrl_pkg::IDX_CH_FLAG:       rd_val[7:0] = st_reg.ch_flag;
			timer_ctrl_pkg::IDX_OVF_FLAG:      rd_val[7:0] = st_reg.ovf_flag;
			timer_ctrl_pkg::IDX_PA_CTRL:       rd_val[7:0] = st_reg.pa_ctrl;
			timer_ctrl_pkg::IDX_CH7_MASK:      rd_val[7:0] = st_reg.ch7_mask;
			timer_ctrl_pkg::IDX_PIN_DISC:      rd_val[7:0] = st_reg.pin_disc;
			timer_ctrl_pkg::IDX_PREC_PRESCALE:
				rd_val[7:0] = st_reg.prec_prescale;
			default:
			begin
				if (cmp_sel)
					rd_val[15:0] = st_reg.cmp_val[cmp_ch];
				else
					mapped = 1'b0;
			end
		endcase
	end

	// Next state: pins, prescaler, counter, bus writes and flags.
	always_comb
	begin
		st_next = st_reg;
		clr_ch  = timer_ctrl_pkg::RST_BYTE;
		clr_ovf = 1'b0;
		ovf_set = 1'b0;

		// Two-stage pin synchroniser and the previous sample.
		st_next.in_meta = I_CH_PIN;
		st_next.in_sync = st_reg.in_meta;
		st_next.in_prev = st_reg.in_sync;

		// A new factor loads only when the stages wrap, or while stopped.
		if (!timer_en || tick)
		begin
			st_next.pre_cnt    = timer_ctrl_pkg::RST_BYTE;
			st_next.pre_div_m1 = div_m1_sel;
		end
		else
			st_next.pre_cnt = 8'(st_reg.pre_cnt + timer_ctrl_pkg::PRE_ONE);

		// Counter: modulus reset on channel 7 match, else free-running.
		if (tick)
		begin
			if (cnt_rst_7 && hit[7])
				st_next.free_counter = timer_ctrl_pkg::RST_WORD;
			else
				st_next.free_counter = 16'(st_reg.free_counter
					+ timer_ctrl_pkg::CNT_ONE);
			ovf_set = (st_reg.free_counter == timer_ctrl_pkg::CNT_MAX)
				&& !(cnt_rst_7 && hit[7]);
		end

		// Captures latch the count into the channel value.
		for (int i = 0; i < 8; i++)
		begin
			if (cap[i])
				st_next.cmp_val[i] = st_reg.free_counter;
		end
		st_next.out_line = out_next;

		// Register writes take effect at the access edge.
		if (access && I_APB.pwrite)
		begin
			case (idx)
				timer_ctrl_pkg::IDX_CAPCMP_SEL:
					st_next.capcmp_sel = I_APB.pwdata[7:0];
				timer_ctrl_pkg::IDX_SYSCTL_ONE:
				begin
					st_next.sysctl_one = I_APB.pwdata[7:0]
						& timer_ctrl_pkg::SYSCTL_ONE_MASK;
					// Precision select may be written once after reset.
					if (st_reg.prec_locked)
						st_next.sysctl_one[timer_ctrl_pkg::BIT_PREC_SEL] =
							st_reg.sysctl_one[timer_ctrl_pkg::BIT_PREC_SEL];
					st_next.prec_locked = 1'b1;
				end
				timer_ctrl_pkg::IDX_CMP_ACT_HI:
					st_next.cmp_act_hi = I_APB.pwdata[7:0];
				timer_ctrl_pkg::IDX_CMP_ACT_LO:
					st_next.cmp_act_lo = I_APB.pwdata[7:0];
				timer_ctrl_pkg::IDX_EDGE_HI:
					st_next.edge_hi = I_APB.pwdata[7:0];
				timer_ctrl_pkg::IDX_EDGE_LO:
					st_next.edge_lo = I_APB.pwdata[7:0];
				timer_ctrl_pkg::IDX_CH_IRQ_EN:
					st_next.ch_irq_en = I_APB.pwdata[7:0];
				timer_ctrl_pkg::IDX_SYSCTL_TWO:
					st_next.sysctl_two = I_APB.pwdata[7:0]
						& timer_ctrl_pkg::SYSCTL_TWO_MASK;
				timer_ctrl_pkg::IDX_CH_FLAG:
				begin
					if (timer_en || st_reg.pa_ctrl[timer_ctrl_pkg::BIT_PA_EN])
						clr_ch = I_APB.pwdata[7:0];
				end
				timer_ctrl_pkg::IDX_OVF_FLAG:
				begin
					if (timer_en || st_reg.pa_ctrl[timer_ctrl_pkg::BIT_PA_EN])
						clr_ovf = I_APB.pwdata[
							timer_ctrl_pkg::BIT_OVF_FLAG];
				end
				timer_ctrl_pkg::IDX_PA_CTRL:
					st_next.pa_ctrl = I_APB.pwdata[7:0]
						& timer_ctrl_pkg::PA_CTRL_MASK;
				timer_ctrl_pkg::IDX_CH7_MASK:
					st_next.ch7_mask = I_APB.pwdata[7:0];
				timer_ctrl_pkg::IDX_PIN_DISC:
					st_next.pin_disc = I_APB.pwdata[7:0];
				timer_ctrl_pkg::IDX_PREC_PRESCALE:
					st_next.prec_prescale = I_APB.pwdata[7:0];
				default:
				begin
					// Value writes mean nothing on a capture channel.
					if (cmp_sel && st_reg.capcmp_sel[cmp_ch])
					begin
						st_next.cmp_val[cmp_ch] = I_APB.pwdata[15:0];
						if (fast_clear)
							clr_ch[cmp_ch] = 1'b1;
					end
				end
			endcase
		end

		// Fast clear by reading a capture value or touching the counter.
		if (access && !I_APB.pwrite && cmp_sel && fast_clear
			&& !st_reg.capcmp_sel[cmp_ch])
			clr_ch[cmp_ch] = 1'b1;
		if (access && fast_clear && idx == timer_ctrl_pkg::IDX_FREE_COUNTER)
			clr_ovf = 1'b1;

		// Flags: a new event wins over a clear in the same cycle.
		st_next.ch_flag = (st_reg.ch_flag & ~clr_ch) | hit | cap;
		st_next.ovf_flag[timer_ctrl_pkg::BIT_OVF_FLAG] =
			(st_reg.ovf_flag[timer_ctrl_pkg::BIT_OVF_FLAG] && !clr_ovf)
			|| ovf_set;

		// Read data is latched in the setup cycle and held for access.
		if (setup)
			st_next.rdata = rd_val;
	end

	// State register; synchronous reset clears everything.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_RST)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

endmodule // timer_ctrl

`default_nettype wire

// ---- timer_ctrl_monitor.sv ----
// Port checker of the timer control block.
// Assumes a bind to timer_ctrl; APB writes land at the access edge.
`timescale 1ns/100ps
`default_nettype none
module timer_ctrl_monitor
(
	// Watched ports.
	input wire logic                        I_CLK_SYS,
	input wire logic                        I_RST,
	input wire timer_ctrl_pkg::apb_req_type I_APB,
	input wire timer_ctrl_pkg::apb_rsp_type O_APB,
	input wire logic [7:0]                  I_CH_PIN,
	input wire logic [7:0]                  O_CH_PIN,
	input wire logic [7:0]                  O_CH_PIN_OE_N,
	input wire logic [7:0]                  O_CH_IRQ,
	input wire logic                        O_OVF_IRQ
);
	logic [7:0] sh_reg [0:63];
	logic [7:0] act;
	logic [7:0] live;
	logic [7:0] hit;
	logic [7:0] idx;
	logic       acc;
	logic       timer_enable_bit;
	logic       pa;
	logic       fast;
	// Shadow bytes; upper index bits alias, so only writes below index 64 are safe.
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_RST)
			sh_reg <= '{default: 8'h00};
		else if (acc && I_APB.pwrite)
			sh_reg[idx[5:0]] <= I_APB.pwdata[7:0];
	end
	// Decoded controls and the channel touched by a fast-clear access.
	always_comb
	begin
		acc = I_APB.psel & I_APB.penable;
		idx = I_APB.paddr[9:2];
		timer_enable_bit = sh_reg[6][7];
		fast = sh_reg[6][4];
		pa = sh_reg[32][6];
		for (int c = 0; c < 8; c++)
		begin
			act[c] = |({sh_reg[8], sh_reg[9]} >> (2 * c) & 16'h0003);
			hit[c] = acc && idx == 8'h10 + 8'(2 * c)
				&& I_APB.pwrite == sh_reg[0][c];
		end
		live = act & ~sh_reg[36];
	end
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RST);
	// Timer off for two edges with steady enables.
	sequence s_timer_idle;
		!timer_enable_bit && !$past(timer_enable_bit) && $stable(sh_reg[12]) && $stable(sh_reg[13]);
	endsequence
	sequence s_flag_write;
		acc && I_APB.pwrite && idx == 8'h0E && !timer_enable_bit;
	endsequence
	a_irq_enable_gate: assert property (
		(O_CH_IRQ & ~sh_reg[12]) == 8'h00) else $error("irq not enabled");
	a_ovf_enable_gate: assert property (
		O_OVF_IRQ |-> sh_reg[13][7]) else $error("ovf irq not enabled");
	a_pin_drive_enable: assert property (
		O_CH_PIN_OE_N == ~(act & ~sh_reg[37])) else $error("pin enable");
	a_pin_idle_hold: assert property (
		((O_CH_PIN ^ $past(O_CH_PIN)) & ~(live | $past(live))) == 8'h00)
		else $error("pin moved without action");
	a_timer_stop_quiet: assert property (
		s_timer_idle |-> (O_CH_IRQ & ~$past(O_CH_IRQ)) == 8'h00
		&& !$rose(O_OVF_IRQ) && $stable(O_CH_PIN)) else $error("timer ran");
	a_clear_refused: assert property (
		(s_flag_write and !pa) |=> O_CH_IRQ == $past(O_CH_IRQ))
		else $error("flag cleared while disabled");
	a_clear_taken: assert property (
		(s_flag_write and pa) |=> (O_CH_IRQ & $past(I_APB.pwdata[7:0])) == 8'h00)
		else $error("flag not cleared");
	a_fast_value_clear: assert property (
		fast && !timer_enable_bit && pa && hit != 8'h00 |=> (O_CH_IRQ & $past(hit)) == 8'h00)
		else $error("fast clear of channel flag missed");
	a_fast_count_clear: assert property (
		fast && !timer_enable_bit && pa && acc && idx == 8'h04 |=> !O_OVF_IRQ)
		else $error("fast clear of overflow missed");
endmodule // timer_ctrl_monitor
`default_nettype wire

// ---- timer_ctrl_pins.sv ----
// Model of the timer pins and the signal sources outside them.
// Assumes the bench sets the source levels; no pull on the lines.
`timescale 1ns/100ps
`default_nettype none
module timer_ctrl_pins
(
	// Block side.
	input  wire logic [7:0] i_pin_out,
	input  wire logic [7:0] i_pin_oe_n,
	// Outside sources and the resolved wire.
	input  wire logic [7:0] i_source,
	output logic [7:0]      o_level
);
	// The block wins where it drives; the outside source holds the rest.
	assign o_level = (i_pin_out & ~i_pin_oe_n) | (i_source & i_pin_oe_n);
endmodule // timer_ctrl_pins
`default_nettype wire

// ---- timer_ctrl_pkg.sv ----
// Constants and carrier types of the eight-channel timer control block.
// Assumes an APB master with 32-bit data; registers sit one to a word.
`default_nettype none

package timer_ctrl_pkg;

	// Bus geometry.
	localparam int ADDR_W = 10;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] IDX_CAPCMP_SEL    = 8'h00;
	localparam logic [7:0] IDX_FREE_COUNTER  = 8'h04;
	localparam logic [7:0] IDX_SYSCTL_ONE    = 8'h06;
	localparam logic [7:0] IDX_CMP_ACT_HI    = 8'h08;
	localparam logic [7:0] IDX_CMP_ACT_LO    = 8'h09;
	localparam logic [7:0] IDX_EDGE_HI       = 8'h0A;
	localparam logic [7:0] IDX_EDGE_LO       = 8'h0B;
	localparam logic [7:0] IDX_CH_IRQ_EN     = 8'h0C;
	localparam logic [7:0] IDX_SYSCTL_TWO    = 8'h0D;
	localparam logic [7:0] IDX_CH_FLAG       = 8'h0E;
	localparam logic [7:0] IDX_OVF_FLAG      = 8'h0F;
	localparam logic [3:0] IDX_CMP_VAL_HIGH  = 4'h1;
	localparam logic [7:0] IDX_PA_CTRL       = 8'h20;
	localparam logic [7:0] IDX_CH7_MASK      = 8'h24;
	localparam logic [7:0] IDX_PIN_DISC      = 8'h25;
	localparam logic [7:0] IDX_PREC_PRESCALE = 8'h26;

	// Field positions.
	localparam int BIT_TIMER_EN   = 7;
	localparam int BIT_FAST_CLEAR = 4;
	localparam int BIT_PREC_SEL   = 3;
	localparam int BIT_OVF_IRQ_EN = 7;
	localparam int BIT_CNT_RST_7  = 3;
	localparam int BIT_PA_EN      = 6;
	localparam int BIT_OVF_FLAG   = 7;
	localparam int PRESCALE_W     = 3;

	// Writable-bit masks; other bits read as zero.
	localparam logic [7:0] SYSCTL_ONE_MASK = 8'hF8;
	localparam logic [7:0] SYSCTL_TWO_MASK = 8'h8F;
	localparam logic [7:0] PA_CTRL_MASK    = 8'h7F;

	// Reset and limit values.
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [31:0] RST_DATA = 32'h0000_0000;
	localparam logic [15:0] CNT_MAX  = 16'hFFFF;
	localparam logic [15:0] CNT_ONE  = 16'h0001;
	localparam logic [7:0]  PRE_ONE  = 8'h01;

	// APB request from the master.
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} apb_req_type;

	// APB answer to the master.
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_type;

	// Whole state of the timer control block.
	typedef struct packed {
		logic [7:0]       capcmp_sel;
		logic [7:0]       cmp_act_hi;
		logic [7:0]       cmp_act_lo;
		logic [7:0]       edge_hi;
		logic [7:0]       edge_lo;
		logic [7:0]       ch_irq_en;
		logic [7:0]       sysctl_one;
		logic [7:0]       sysctl_two;
		logic [7:0]       ch_flag;
		logic [7:0]       ovf_flag;
		logic [7:0]       pa_ctrl;
		logic [7:0]       ch7_mask;
		logic [7:0]       pin_disc;
		logic [7:0]       prec_prescale;
		logic             prec_locked;
		logic [15:0]      free_counter;
		logic [7:0]       pre_cnt;
		logic [7:0]       pre_div_m1;
		logic [7:0][15:0] cmp_val;
		logic [7:0]       out_line;
		logic [7:0]       in_meta;
		logic [7:0]       in_sync;
		logic [7:0]       in_prev;
		logic [31:0]      rdata;
	} tim_state_type;

endpackage

`default_nettype wire
